// >>> dpmb_pkg.sv
package dpmb_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ADDR_W = 17;
  localparam int DATA_W = 36;
  localparam int LANE_W = 4;
  localparam int CNT_W = 4;
  localparam int SYNC_STAGES = 2;

  // ****************************************************************
  // Mailbox locations
  // ****************************************************************
  localparam logic [ADDR_W-1:0] MBOX_LEFT_ADDR = 17'h1_FFFE;
  localparam logic [ADDR_W-1:0] MBOX_RIGHT_ADDR = 17'h1_FFFF;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_BUSY_NS = 15;
  localparam int T_ACCESS_NS = 15;
  localparam int T_WRITE_PULSE_NS = 12;
  localparam int BUSY_CYC = (T_BUSY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Pin inputs pass the synchroniser before use
  localparam int SETUP_CYC = BUSY_CYC + SYNC_STAGES;
  localparam int STROBE_CYC = ((ACC_CYC > WP_CYC) ? ACC_CYC : WP_CYC) + SYNC_STAGES;
  localparam logic [CNT_W-1:0] SETUP_LAST = CNT_W'(SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] STROBE_LAST = CNT_W'(STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    DPMB_OP_READ,
    DPMB_OP_WRITE,
    DPMB_OP_SEM_READ,
    DPMB_OP_SEM_WRITE
  } dpmb_op_e;

  typedef struct packed {
    dpmb_op_e op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [LANE_W-1:0] lanes;
  } dpmb_cmd_s;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic rw_n;
    logic port_select_n;
    logic semaphore_select_n;
    logic oe_n;
    logic [LANE_W-1:0] byte_lane_enable_n;
  } dpmb_pins_s;

  localparam logic [LANE_W-1:0] SEM_LANES_N = 4'hE;

endpackage

// >>> dpmb_port_ctrl.sv
`timescale 1ns/1ps

// Operation
// [RQ1] Right write to 1FFFE sets left flag
// [RQ2] Left select plus output enable at 1FFFE clears
// [RQ3] Left write to 1FFFF sets right flag
// [RQ4] Right reads 1FFFF to clear its flag
// [RQ5] Mailbox words stay ordinary user storage
// [RQ6] Unused mailboxes behave as plain locations
// [RQ7] Flag changes only while busy is high
// [RQ8] Controller clears its flag after reset
// [RQ9] Master busy low only on matched selected addresses
// [RQ10] Later settling port gets busy low
// [RQ11] Near ties still busy exactly one side
// [RQ12] Master suppresses writes on busy-low port
// [RQ13] Master drives busy, slave takes busy input
// [RQ14] Slave busy is write inhibit only
// [RQ15] Slave busy held high, low blocks writes
// [RQ16] Depth expansion ANDs busy indications
// [RQ17] Busy may flag illegal simultaneous access
// [RQ18] Eight semaphores, write bit 0, read all
// [RQ19] Semaphore access: port select high, semaphore low
// [RQ20] Writing 0 takes token, other reads 1
// [RQ21] Other side's 0 kept as pending request
// [RQ22] Release passes token to pending requester
// [RQ23] Deselected port stands by, selected sees all
// [RQ24] Arbitration ignores read or write
// [RQ25] Drop select or enable between semaphore reads
module dpmb_port_ctrl #(
  parameter bit PORT_IS_LEFT = 1'b1,
  parameter int N_DEV = 1
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic cmd_valid,
  input wire dpmb_pkg::dpmb_cmd_s cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [dpmb_pkg::DATA_W-1:0] rsp_data,
  output logic rsp_busy,
  input wire logic slave_mode,
  input wire logic write_block,
  output logic mailbox_pending,
  output logic contention_pulse,
  output dpmb_pkg::dpmb_pins_s pins,
  input wire logic [dpmb_pkg::DATA_W-1:0] data_in,
  output logic [dpmb_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [N_DEV-1:0] busy_in_n,
  output logic busy_out_n,
  output logic busy_oe,
  input wire logic mailbox_flag_n
);

  if (N_DEV < 1) $error("N_DEV must be at least 1");
  if (dpmb_pkg::STROBE_CYC > 16 || dpmb_pkg::SETUP_CYC > 16) $error("Counter too narrow");

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  localparam logic [dpmb_pkg::ADDR_W-1:0] OWN_MBOX =
    PORT_IS_LEFT ? dpmb_pkg::MBOX_LEFT_ADDR : dpmb_pkg::MBOX_RIGHT_ADDR; // RQ2 RQ4

  logic [dpmb_pkg::DATA_W-1:0] data_s1_q, data_s2_q;
  logic busy_s1_q, busy_s2_q, busy_prev_q;
  logic mbox_s1_q, mbox_s2_q;
  logic busy_all_n;

  assign busy_all_n = &busy_in_n; // RQ16

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      data_s1_q <= '0;
      data_s2_q <= '0;
      busy_s1_q <= 1'b1;
      busy_s2_q <= 1'b1;
      busy_prev_q <= 1'b1;
      mbox_s1_q <= 1'b1;
      mbox_s2_q <= 1'b1;
    end
    else
    begin
      data_s1_q <= data_in;
      data_s2_q <= data_s1_q;
      busy_s1_q <= busy_all_n;
      busy_s2_q <= busy_s1_q;
      busy_prev_q <= busy_s2_q;
      mbox_s1_q <= mailbox_flag_n;
      mbox_s2_q <= mbox_s1_q;
    end
  end

  assign mailbox_pending = ~mbox_s2_q;
  assign contention_pulse = busy_prev_q & ~busy_s2_q; // RQ17

  // ****************************************************************
  // Slave busy drive
  // ****************************************************************
  logic busy_oe_q, busy_oe_d, busy_out_q, busy_out_d;

  always_comb
  begin
    busy_oe_d = slave_mode; // RQ13
    busy_out_d = slave_mode ? ~write_block : 1'b1; // RQ15
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      busy_oe_q <= 1'b0;
      busy_out_q <= 1'b1;
    end
    else
    begin
      busy_oe_q <= busy_oe_d;
      busy_out_q <= busy_out_d;
    end
  end

  assign busy_oe = busy_oe_q;
  assign busy_out_n = busy_out_q;

  // ****************************************************************
  // Access sequencer
  // ****************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_RECOVER} dpmb_state_e;

  localparam dpmb_pkg::dpmb_pins_s PINS_IDLE = '{
    addr: '0, rw_n: 1'b1, port_select_n: 1'b1, semaphore_select_n: 1'b1,
    oe_n: 1'b1, byte_lane_enable_n: '1};

  dpmb_state_e state_q, state_d;
  dpmb_pkg::dpmb_cmd_s cur_q, cur_d;
  dpmb_pkg::dpmb_pins_s pins_q, pins_d;
  logic [dpmb_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic [dpmb_pkg::DATA_W-1:0] dout_q, dout_d, rsp_data_q, rsp_data_d;
  logic doe_q, doe_d, init_q, init_d, seen_q, seen_d;
  logic rsp_valid_q, rsp_valid_d, rsp_busy_q, rsp_busy_d;
  logic is_sem, is_write, need_wait, busy_low;
  dpmb_pkg::dpmb_cmd_s next_cmd;

  assign busy_low = ~busy_s2_q & ~slave_mode; // RQ14
  assign is_sem = cur_q.op inside {dpmb_pkg::DPMB_OP_SEM_READ, dpmb_pkg::DPMB_OP_SEM_WRITE};
  assign is_write = cur_q.op inside {dpmb_pkg::DPMB_OP_WRITE, dpmb_pkg::DPMB_OP_SEM_WRITE};
  // Flag clear needs busy high too, and both may be refused
  assign need_wait = ~is_sem & (is_write | init_q); // RQ7 RQ12
  assign cmd_ready = (state_q == ST_IDLE) & ~init_q;

  always_comb
  begin
    next_cmd = cmd;
    if (init_q)
    begin
      next_cmd.op = dpmb_pkg::DPMB_OP_READ; // RQ8
      next_cmd.addr = OWN_MBOX;
      next_cmd.data = '0;
      next_cmd.lanes = '1;
    end
  end

  always_comb
  begin
    state_d = state_q;
    cur_d = cur_q;
    pins_d = pins_q;
    cnt_d = cnt_q;
    dout_d = dout_q;
    doe_d = doe_q;
    init_d = init_q;
    seen_d = seen_q;
    rsp_valid_d = 1'b0;
    rsp_data_d = rsp_data_q;
    rsp_busy_d = rsp_busy_q;
    case (state_q)
      ST_IDLE:
      begin
        if (init_q || cmd_valid)
        begin
          cur_d = next_cmd;
          pins_d = PINS_IDLE;
          pins_d.addr = next_cmd.addr;
          if (next_cmd.op inside {dpmb_pkg::DPMB_OP_SEM_READ, dpmb_pkg::DPMB_OP_SEM_WRITE})
          begin
            pins_d.semaphore_select_n = 1'b0; // RQ19
            pins_d.byte_lane_enable_n = dpmb_pkg::SEM_LANES_N;
            dout_d = {dpmb_pkg::DATA_W{next_cmd.data[0]}}; // RQ18
          end
          else
          begin
            pins_d.port_select_n = 1'b0; // RQ23
            pins_d.byte_lane_enable_n = ~next_cmd.lanes;
            dout_d = next_cmd.data;
          end
          doe_d = next_cmd.op inside {dpmb_pkg::DPMB_OP_WRITE, dpmb_pkg::DPMB_OP_SEM_WRITE};
          seen_d = 1'b0;
          cnt_d = dpmb_pkg::SETUP_LAST;
          state_d = ST_SETUP;
        end
      end
      ST_SETUP:
      begin
        if (busy_low)
          seen_d = 1'b1;
        if (cnt_q != dpmb_pkg::CNT_ZERO)
          cnt_d = cnt_q - dpmb_pkg::CNT_ONE;
        else if (!(need_wait && busy_low)) // RQ10 RQ11
        begin
          if (is_write)
            pins_d.rw_n = 1'b0;
          else
            pins_d.oe_n = 1'b0;
          cnt_d = dpmb_pkg::STROBE_LAST;
          state_d = ST_STROBE;
        end
      end
      ST_STROBE:
      begin
        if (busy_low && !is_sem)
          seen_d = 1'b1;
        if (cnt_q != dpmb_pkg::CNT_ZERO)
          cnt_d = cnt_q - dpmb_pkg::CNT_ONE;
        else
        begin
          pins_d.rw_n = 1'b1;
          pins_d.oe_n = 1'b1;
          rsp_data_d = data_s2_q; // RQ20 RQ21 RQ22
          rsp_busy_d = seen_q | (busy_low & ~is_sem);
          rsp_valid_d = ~init_q;
          init_d = 1'b0;
          state_d = ST_RECOVER;
        end
      end
      ST_RECOVER:
      begin
        pins_d = PINS_IDLE; // RQ25
        pins_d.addr = pins_q.addr;
        doe_d = 1'b0;
        state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
        pins_d = PINS_IDLE;
        doe_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      cur_q <= '0;
      pins_q <= PINS_IDLE;
      cnt_q <= dpmb_pkg::CNT_ZERO;
      dout_q <= '0;
      doe_q <= 1'b0;
      init_q <= 1'b1;
      seen_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= '0;
      rsp_busy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cur_q <= cur_d;
      pins_q <= pins_d;
      cnt_q <= cnt_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      init_q <= init_d;
      seen_q <= seen_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_data_q <= rsp_data_d;
      rsp_busy_q <= rsp_busy_d;
    end
  end

  assign pins = pins_q;
  assign data_out = dout_q;
  assign data_oe = doe_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign rsp_busy = rsp_busy_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_strobe_end;
    $rose(pins_q.oe_n) || $rose(pins_q.rw_n);
  endsequence

  sequence s_deselected;
    pins_q.port_select_n && pins_q.semaphore_select_n && pins_q.oe_n;
  endsequence

  chk_sem_select: assert property ( // RQ19
    !pins_q.semaphore_select_n |-> pins_q.port_select_n)
    else $error("Semaphore access with port select low");
  chk_recover_gap: assert property (s_strobe_end |=> s_deselected) // RQ25
    else $error("Selects not dropped after access");
  chk_write_wait: assert property ( // RQ12
    ($fell(pins_q.rw_n) && !pins_q.port_select_n && !$past(slave_mode)) |-> $past(busy_s2_q))
    else $error("Write strobe started while busy low");
  chk_init_clear: assert property ($fell(init_q) |-> $past(cur_q.addr) == OWN_MBOX // RQ8
    && $past(pins_q.rw_n) && !rsp_valid_q)
    else $error("First access was not the own mailbox clear");
  chk_init_blocks: assert property (init_q |-> !cmd_ready) // RQ8
    else $error("Command taken before flag init");
  chk_slave_drive: assert property (slave_mode |=> busy_oe && busy_out_n == !$past(write_block)) // RQ15
    else $error("Slave busy pin not driven from write block");
  chk_master_release: assert property (!slave_mode |=> !busy_oe && busy_out_n) // RQ13
    else $error("Busy pin driven in master mode");
  chk_sem_bit0: assert property ( // RQ18
    (!pins_q.semaphore_select_n && data_oe) |-> data_out == {dpmb_pkg::DATA_W{data_out[0]}})
    else $error("Semaphore write data not bit 0");
  chk_strobe_len: assert property ($fell(pins_q.oe_n) |-> !pins_q.oe_n [*4] ##1 pins_q.oe_n) // RQ7
    else $error("Read strobe length wrong");
  chk_contention: assert property ( // RQ17
    ($past(reset_n, 3) && $past(busy_all_n, 3) && !$past(busy_all_n, 2)) |-> contention_pulse)
    else $error("Busy pin fall not reported as contention");

endmodule

// >>> dpmb_dev_model.sv
`timescale 1ns/1ps

// ********
// Dual-port device, both ports
// ********
module dpmb_dev_model (
  input wire logic clk_sys,
  input wire dpmb_pkg::dpmb_pins_s pins [2],
  input wire logic [35:0] din [2],
  input wire logic [1:0] busy_n,
  output logic [35:0] dout [2],
  output logic [1:0] arb_n,
  output logic [1:0] flag_n
);
  logic [35:0] mem [logic [16:0]];
  logic [7:0] tok [2];
  logic [7:0] req [2];
  logic [35:0] slat [2];
  logic [1:0] rdq;
  logic [1:0] was;
  logic match;
  function automatic logic [16:0] mbx(input int s);
    return s ? dpmb_pkg::MBOX_RIGHT_ADDR : dpmb_pkg::MBOX_LEFT_ADDR;
  endfunction
  initial
  begin
    tok = '{8'h00, 8'h00};
    req = '{8'h00, 8'h00};
    dout = '{36'h0, 36'h0};
    rdq = 2'b00;
    was = 2'b00;
    arb_n = 2'b11;
    flag_n = 2'b00;
  end
  assign match = !pins[0].port_select_n && !pins[1].port_select_n
    && pins[0].addr == pins[1].addr;
  always @(posedge clk_sys)
  begin
    was <= {!pins[1].port_select_n, !pins[0].port_select_n};
    if (!match) arb_n <= 2'b11;
    else if (arb_n == 2'b11) arb_n <= (was == 2'b10) ? 2'b10 : 2'b01;
  end
  always @(posedge clk_sys)
  begin
    for (int p = 0; p < 2; p++)
    begin
      automatic dpmb_pkg::dpmb_pins_s c = pins[p];
      automatic int o = 1 - p;
      automatic logic [2:0] k = c.addr[2:0];
      if (!c.port_select_n && !c.rw_n && busy_n[p])
      begin
        mem[c.addr] = din[p];
        if (c.addr == mbx(o)) flag_n[o] <= 1'b0;
      end
      if (!c.port_select_n && !c.oe_n && c.addr == mbx(p) && busy_n[p])
        flag_n[p] <= 1'b1;
      if (!c.semaphore_select_n && !c.rw_n)
      begin
        if (!din[p][0])
        begin
          if (!tok[o][k]) tok[p][k] = 1'b1;
          else req[p][k] = 1'b1;
        end
        else if (tok[p][k])
        begin
          tok[p][k] = 1'b0;
          tok[o][k] = req[o][k];
          req[o][k] = 1'b0;
        end
        else req[p][k] = 1'b0;
      end
      if (!c.semaphore_select_n && !c.oe_n && !rdq[p])
        slat[p] = {36{!tok[p][k]}};
      rdq[p] <= !c.semaphore_select_n && !c.oe_n;
      if (c.oe_n) dout[p] <= ~dout[p];
      else if (!c.semaphore_select_n) dout[p] <= slat[p];
      else dout[p] <= mem.exists(c.addr) ? mem[c.addr] : 36'h0;
    end
  end
endmodule

// >>> tb.sv
`timescale 1ns/1ps

// ********
// Two port controllers on one device
// ********
module tb;
  localparam dpmb_pkg::dpmb_op_e WR = dpmb_pkg::DPMB_OP_WRITE;
  localparam dpmb_pkg::dpmb_op_e RD = dpmb_pkg::DPMB_OP_READ;
  localparam dpmb_pkg::dpmb_op_e SW = dpmb_pkg::DPMB_OP_SEM_WRITE;
  localparam dpmb_pkg::dpmb_op_e SR = dpmb_pkg::DPMB_OP_SEM_READ;
  localparam logic [16:0] ML = dpmb_pkg::MBOX_LEFT_ADDR;
  localparam logic [16:0] MR = dpmb_pkg::MBOX_RIGHT_ADDR;
  localparam logic [3:0] SEQ [10] = '{4'h1, 4'h9, 4'h6, 4'h2, 4'hD, 4'h7, 4'hA, 4'hF, 4'h1, 4'h7};
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic slave_mode = 1'b0;
  logic [1:0] cv = 2'b00;
  logic [1:0] wb = 2'b00;
  dpmb_pkg::dpmb_cmd_s cm [2] = '{default: '0};
  wire [1:0] rv, rb, cr, mp, doe, boe, bo, bn, arb, fl, cp;
  wire dpmb_pkg::dpmb_pins_s pins [2];
  wire [35:0] rd [2];
  wire [35:0] dq [2];
  wire [35:0] dm [2];
  logic [35:0] q;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int pulse_l = 0;
  int pulse_r = 0;
  always #5 clk_sys = ~clk_sys;
  for (genvar g = 0; g < 2; g++)
  begin : gp
    assign bn[g] = boe[g] ? bo[g] : (slave_mode | arb[g]);
    dpmb_port_ctrl #(.PORT_IS_LEFT(g == 0)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
      .cmd_valid(cv[g]), .cmd(cm[g]), .cmd_ready(cr[g]), .rsp_valid(rv[g]),
      .rsp_data(rd[g]), .rsp_busy(rb[g]), .slave_mode(slave_mode), .write_block(wb[g]),
      .mailbox_pending(mp[g]), .contention_pulse(cp[g]), .pins(pins[g]),
      .data_in(doe[g] ? dq[g] : dm[g]), .data_out(dq[g]), .data_oe(doe[g]),
      .busy_in_n(bn[g]), .busy_out_n(bo[g]), .busy_oe(boe[g]), .mailbox_flag_n(fl[g]));
  end
  dpmb_dev_model dev (.clk_sys(clk_sys), .pins(pins), .din(dq), .busy_n(bn), .dout(dm),
    .arb_n(arb), .flag_n(fl));
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xf(input int s, input dpmb_pkg::dpmb_op_e o, input logic [16:0] a,
    input logic [35:0] d);
    while (cr[s] !== 1'b1) @(negedge clk_sys);
    cm[s] = '{op: o, addr: a, data: d, lanes: 4'hF};
    cv[s] = 1'b1;
    @(negedge clk_sys);
    cv[s] = 1'b0;
    while (rv[s] !== 1'b1) @(negedge clk_sys);
    q = rd[s];
  endtask
  task automatic pend(input int s, input logic e);
    repeat (5) @(negedge clk_sys);
    chk(36'(mp[s]), 36'(e));
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cp[0] === 1'b1) pulse_l++;
    if (cp[1] === 1'b1) pulse_r++;
    if (cyc == 5000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  initial
  begin
    repeat (8) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (20) @(negedge clk_sys);
    pend(0, 1'b0);
    pend(1, 1'b0);
    chk(36'(bn), 36'h3);
    xf(0, WR, MR, 36'h1_2345_6789);
    pend(1, 1'b1);
    pend(0, 1'b0);
    xf(1, RD, MR, 36'h0);
    chk(q, 36'h1_2345_6789);
    pend(1, 1'b0);
    xf(1, WR, ML, 36'h9_8765_4321);
    pend(0, 1'b1);
    xf(0, RD, ML, 36'h0);
    chk(q, 36'h9_8765_4321);
    pend(0, 1'b0);
    xf(0, WR, 17'h0_0123, 36'hA_5A5A_5A5A);
    xf(1, RD, 17'h0_0123, 36'h0);
    chk(q, 36'hA_5A5A_5A5A);
    fork
      xf(0, WR, 17'h0_0300, 36'h0_0000_00AA);
      xf(1, WR, 17'h0_0300, 36'h0_0000_00BB);
    join
    chk(36'(rb), 36'h2);
    chk(36'(pulse_r), 36'h1);
    chk(36'(pulse_l), 36'h0);
    xf(0, RD, 17'h0_0300, 36'h0);
    chk(q, 36'h0_0000_00BB);
    foreach (SEQ[i])
    begin
      xf(SEQ[i][3], SW, 17'h0_0005, 36'(SEQ[i][2]));
      xf(0, SR, 17'h0_0005, 36'h0);
      chk(q, {36{SEQ[i][1]}});
      xf(1, SR, 17'h0_0005, 36'h0);
      chk(q, {36{SEQ[i][0]}});
    end
    xf(0, SW, 17'h0_0002, 36'h0);
    xf(1, SR, 17'h0_0002, 36'h0);
    chk(q, {36{1'b1}});
    xf(1, SR, 17'h0_0005, 36'h0);
    chk(q, {36{1'b1}});
    slave_mode = 1'b1;
    xf(0, WR, 17'h0_0200, 36'h0_0000_1111);
    wb[0] = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(36'(bn), 36'h2);
    xf(0, WR, 17'h0_0200, 36'h0_0000_2222);
    xf(1, RD, 17'h0_0200, 36'h0);
    chk(q, 36'h0_0000_1111);
    chk(36'(pulse_l), 36'h1);
    end_sim();
  end
endmodule
